// *** ssi_pkg.sv ***
// Package for the side sign indicator: constants, register map, types
package ssi_pkg;

  // ==========================================================================
  // Indicator codes
  localparam logic [1:0] SSI_IND_NA     = 2'h0;
  localparam logic [1:0] SSI_IND_CLEAR  = 2'h1;
  localparam logic [1:0] SSI_IND_SET    = 2'h2;
  localparam logic [1:0] SSI_IND_BAD    = 2'h3;

  // ==========================================================================
  // Timing
  localparam int unsigned SSI_CLK_HZ      = 200000000;
  localparam int unsigned SSI_TIMEOUT_MS  = 2000;
  localparam int unsigned SSI_TIMEOUT_CYC =
    (SSI_CLK_HZ / 1000) * SSI_TIMEOUT_MS;
  localparam int unsigned SSI_SW_SETTLE_CYC = 4;

  // ==========================================================================
  // Register map (byte addresses, one word each)
  localparam logic [3:0] SSI_REG_CTRL   = 4'h0;
  localparam logic [3:0] SSI_REG_STATUS = 4'h4;

  // CTRL fields
  localparam int SSI_CTRL_SW_EN   = 0;
  localparam int SSI_CTRL_SW_AUTO = 1;
  localparam logic [1:0] SSI_CTRL_RST = 2'h2;

  // STATUS fields
  localparam int SSI_ST_IND_LSB   = 0;
  localparam int SSI_ST_FRESH     = 2;
  localparam int SSI_ST_SW_USED   = 3;
  localparam int SSI_ST_SW_CLOSED = 4;
  localparam int SSI_ST_SW_SEEN   = 5;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       valid;
    logic [3:0] flags;
  } ssi_sentence_t;

  typedef struct packed {
    logic sw_closed;
    logic sw_seen;
  } ssi_switch_t;

endpackage : ssi_pkg

// *** ssi_switch_in.sv ***
// Switch input conditioning: three-flop sync, agreement filter, detection
`timescale 1ns/1ps
`default_nettype none
module ssi_switch_in
  import ssi_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire logic  ce_i,
  input  wire logic  sw_closed_i,
  input  wire logic  sw_driven_i,
  output ssi_switch_t sw_o
);

  logic [2:0]  sync_ff;
  logic [2:0]  nxt_sync;
  logic [2:0]  drv_ff;
  logic [2:0]  nxt_drv;
  ssi_switch_t st_ff;
  ssi_switch_t nxt_st;

  // ==========================================================================
  // Synchronisers; a change counts once stages two and three agree
  always_comb begin
    nxt_sync = {sync_ff[1:0], sw_closed_i};
    nxt_drv  = {drv_ff[1:0], sw_driven_i};
    nxt_st   = st_ff;
    if (sync_ff[1] == sync_ff[2]) begin
      nxt_st.sw_closed = sync_ff[2];
    end
    // A three-state port reports a wired switch; sticky until reset
    if (drv_ff[1] && drv_ff[2]) begin
      nxt_st.sw_seen = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_ff <= 3'h0;
      drv_ff  <= 3'h0;
      st_ff   <= '0;
    end else if (ce_i) begin
      sync_ff <= nxt_sync;
      drv_ff  <= nxt_drv;
      st_ff   <= nxt_st;
    end
  end

  assign sw_o = st_ff;

endmodule // ssi_switch_in
`default_nettype wire

// *** ssi_top.sv ***
// Side sign indicator: sentence decode, freshness timer, switch, registers
`timescale 1ns/1ps
`default_nettype none
module ssi_top
  import ssi_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = SSI_TIMEOUT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Sentence fields from the navigation application
  input  wire logic        snt_valid_i,
  input  wire logic [3:0]  snt_flags_i,
  // Dedicated switch port
  input  wire logic        sw_closed_i,
  input  wire logic        sw_driven_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Indicator for the position report builder
  output logic      [1:0]  smi_o
);

  ssi_sentence_t snt;
  ssi_switch_t   sw;

  logic [31:0] tmr_ff;
  logic [31:0] nxt_tmr;
  logic [1:0]  snt_ind_ff;
  logic [1:0]  nxt_snt_ind;
  logic [1:0]  smi_ff;
  logic [1:0]  nxt_smi;
  logic [1:0]  ctrl_ff;
  logic [1:0]  nxt_ctrl;
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic        fresh;
  logic        sw_used;

  assign snt = '{valid: snt_valid_i, flags: snt_flags_i};

  ssi_switch_in u_sw (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .sw_closed_i (sw_closed_i),
    .sw_driven_i (sw_driven_i),
    .sw_o        (sw)
  );

  // ==========================================================================
  // Sentence path
  function automatic logic [1:0] decode_flags(input logic [3:0] f);
    // Low two bits never reach the result
    logic [1:0] up;
    up = f[3:2];
    case (up)
      SSI_IND_CLEAR: decode_flags = SSI_IND_CLEAR;
      SSI_IND_SET:   decode_flags = SSI_IND_SET;
      SSI_IND_BAD:   decode_flags = SSI_IND_NA;
      default:       decode_flags = SSI_IND_NA;
    endcase
  endfunction

  assign fresh = (tmr_ff != 32'h0);

  always_comb begin
    nxt_tmr     = tmr_ff;
    nxt_snt_ind = snt_ind_ff;
    // Only a valid flag value restarts the two-second window
    if (snt.valid && (snt.flags[3:2] != SSI_IND_BAD)) begin
      nxt_tmr     = TIMEOUT_CYC;
      nxt_snt_ind = decode_flags(snt.flags);
    end else if (tmr_ff != 32'h0) begin
      nxt_tmr = tmr_ff - 32'h1;
    end else begin
      nxt_snt_ind = SSI_IND_NA;
    end
    // An invalid pair forces not available at once
    if (snt.valid && (snt.flags[3:2] == SSI_IND_BAD)) begin
      nxt_snt_ind = SSI_IND_NA;
      nxt_tmr     = 32'h0;
    end
  end

  // ==========================================================================
  // Source selection
  assign sw_used = ctrl_ff[SSI_CTRL_SW_EN] ||
                   (ctrl_ff[SSI_CTRL_SW_AUTO] && sw.sw_seen);

  always_comb begin
    if (sw_used) begin
      nxt_smi = sw.sw_closed ? SSI_IND_SET : SSI_IND_CLEAR;
    end else if (fresh) begin
      nxt_smi = snt_ind_ff;
    end else begin
      nxt_smi = SSI_IND_NA;
    end
  end

  // ==========================================================================
  // Wishbone slave: one wait state, ack for one cycle
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ack  = 1'b0;
    nxt_rdat = rdat_ff;
    if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      nxt_ack  = 1'b1;
      nxt_rdat = 32'h0;
      case (wb_adr_i)
        SSI_REG_CTRL: begin
          nxt_rdat[1:0] = ctrl_ff;
          if (wb_we_i && wb_sel_i[0]) begin
            nxt_ctrl = wb_dat_i[1:0];
          end
        end
        SSI_REG_STATUS: begin
          nxt_rdat[SSI_ST_IND_LSB +: 2] = smi_ff;
          nxt_rdat[SSI_ST_FRESH]        = fresh;
          nxt_rdat[SSI_ST_SW_USED]      = sw_used;
          nxt_rdat[SSI_ST_SW_CLOSED]    = sw.sw_closed;
          nxt_rdat[SSI_ST_SW_SEEN]      = sw.sw_seen;
        end
        default: nxt_rdat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_ff     <= 32'h0;
      snt_ind_ff <= SSI_IND_NA;
      smi_ff     <= SSI_IND_NA;
      ctrl_ff    <= SSI_CTRL_RST;
      ack_ff     <= 1'b0;
      rdat_ff    <= 32'h0;
    end else if (ce_i) begin
      tmr_ff     <= nxt_tmr;
      snt_ind_ff <= nxt_snt_ind;
      smi_ff     <= nxt_smi;
      ctrl_ff    <= nxt_ctrl;
      ack_ff     <= nxt_ack;
      rdat_ff    <= nxt_rdat;
    end
  end

  // Feeds the special manoeuvre field of reports 1, 2 and 3
  assign smi_o    = smi_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

endmodule // ssi_top
`default_nettype wire

// *** ssi_asserts.sv ***
// Checker bound to the side sign indicator top level
`timescale 1ns/1ps
`default_nettype none
module ssi_asserts
  import ssi_pkg::*;
#(parameter int unsigned TIMEOUT_CYC = 50) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        snt_valid_i,
  input wire logic [3:0]  snt_flags_i,
  input wire logic        sw_closed_i,
  input wire logic        sw_driven_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  smi_o
);
  // ==========
  // Helpers: switch ever in use, cycles since last sentence
  logic       sw_any_ff, nxt_sw_any;
  logic [7:0] idle_ff, nxt_idle;
  always_comb begin
    nxt_sw_any = sw_any_ff | sw_driven_i | (wb_cyc_i & wb_stb_i & wb_we_i
      & wb_ack_o & (wb_adr_i == 4'h0) & wb_sel_i[0] & wb_dat_i[0]);
    // Saturates so a long quiet spell never wraps into the fresh window;
    // frozen together with the design while the clock enable is low
    nxt_idle = !ce_i ? idle_ff :
               snt_valid_i ? 8'h0 : idle_ff + {7'h0, idle_ff != 8'hff};
  end
  always_ff @(posedge clk_i) begin
    sw_any_ff <= rst_i ? 1'b0 : nxt_sw_any;
    idle_ff   <= rst_i ? 8'h0 : nxt_idle;
  end
  // ==========
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_na: assert property ($past(rst_i) |-> smi_o == 2'h0 && !wb_ack_o)
    else $error("indicator or ack not idle after reset");
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
    |=> wb_ack_o) else $error("bus request not acked");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_no_bad_code: assert property (smi_o != 2'h3)
    else $error("indicator shows code 3");
  a_snt_map: assert property (snt_valid_i && !sw_any_ff |-> ##3 smi_o ==
    (($past(snt_flags_i[3:2], 3) == 2'h3) ? 2'h0 : $past(snt_flags_i[3:2], 3)))
    else $error("sentence flags mistranslated");
  a_fresh_hold: assert property (idle_ff >= 3 && idle_ff < TIMEOUT_CYC - 2 &&
    !sw_any_ff |-> $stable(smi_o)) else $error("indicator lost while fresh");
  a_timeout_na: assert property (idle_ff >= TIMEOUT_CYC + 4 && !sw_any_ff
    |-> smi_o == SSI_IND_NA) else $error("stale indicator kept");
  a_sw_set: assert property ((sw_any_ff && sw_closed_i)[*8] |-> smi_o == 2'h2)
    else $error("closed switch not shown as set");
  a_sw_clear: assert property ((sw_any_ff && !sw_closed_i)[*8] |-> smi_o == 2'h1)
    else $error("open switch not shown as clear");
  c_invalid: cover property (snt_valid_i && snt_flags_i[3:2] == 2'h3);
  c_expired: cover property (idle_ff == TIMEOUT_CYC + 4);
  c_sw_set: cover property (sw_any_ff && smi_o == SSI_IND_SET);
  c_frozen: cover property (!ce_i && smi_o == SSI_IND_SET);
endmodule // ssi_asserts
bind ssi_top ssi_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (.clk_i, .rst_i,
  .ce_i, .snt_valid_i, .snt_flags_i, .sw_closed_i, .sw_driven_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .smi_o);
`default_nettype wire

// *** ssi_nav_model.sv ***
// Navigation sentence source and cabin switch model
`timescale 1ns/1ps
`default_nettype none
module ssi_nav_model (
  input  wire logic       clk_i,
  output logic            snt_valid_o,
  output logic      [3:0] snt_flags_o,
  output logic            sw_closed_o,
  output logic            sw_driven_o
);
  initial begin
    {snt_valid_o, snt_flags_o, sw_closed_o, sw_driven_o} = 7'h0;
  end
  // Flags are only meaningful with the strobe; scrambled otherwise
  task automatic send(input logic [3:0] f);
    @(posedge clk_i);
    snt_valid_o <= 1'b1;
    snt_flags_o <= f;
    @(posedge clk_i);
    snt_valid_o <= 1'b0;
    snt_flags_o <= ~f;
  endtask
  // Open circuit reads as 0, closed as 1
  task automatic set_sw(input logic drv, input logic cl);
    @(posedge clk_i);
    sw_driven_o <= drv;
    sw_closed_o <= cl;
  endtask
endmodule // ssi_nav_model
`default_nettype wire

// *** side_sign_indicator_tb.sv ***
// Self-checking bench for the side sign indicator
`timescale 1ns/1ps
`default_nettype none
module side_sign_indicator_tb
  import ssi_pkg::*;
;
  localparam int unsigned TO = 50;
  logic clk_i = 0, rst_i = 1, ce = 1, cyc = 0, stb = 0, we = 0;
  logic [3:0] adr = 4'h0, f;
  logic [31:0] dat = 32'h0, q, wb_dat_o;
  logic wb_ack_o, snt_v, sw_c, sw_d;
  logic [3:0] snt_f;
  logic [1:0] smi_o;
  int bad_count = 0, n_checks = 0;
  always #2.5 clk_i = ~clk_i;
  ssi_nav_model nav_u (.clk_i(clk_i), .snt_valid_o(snt_v),
    .snt_flags_o(snt_f), .sw_closed_o(sw_c), .sw_driven_o(sw_d));
  ssi_top #(.TIMEOUT_CYC(TO)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .snt_valid_i(snt_v), .snt_flags_i(snt_f),
    .sw_closed_i(sw_c), .sw_driven_i(sw_d), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .smi_o(smi_o));
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {cyc, stb} <= 2'h0;
  endtask
  task automatic conclude;
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    #20000;
    bad_count++;
    conclude;
  end
  // ==========
  // Sequence
  initial begin
    wt(8);
    rst_i <= 1'b0;
    wb(0, SSI_REG_CTRL, 0); chk(q, 32'h2);
    wb(0, SSI_REG_STATUS, 0); chk(q, 32'h0);
    for (int i = 0; i < 16; i++) begin
      f = i[3:0];
      nav_u.send(f); wt(3);
      chk(smi_o, (f[3:2] == 2'h3) ? 2'h0 : f[3:2]);
    end
    nav_u.send(4'h8); wt(TO - 10);
    nav_u.send(4'h8); wt(TO - 5); chk(smi_o, SSI_IND_SET);
    wt(20); chk(smi_o, SSI_IND_NA);
    // Clock enable low must freeze the freshness timer
    nav_u.send(4'h8); wt(3);
    ce <= 1'b0; wt(TO + 10); chk(smi_o, SSI_IND_SET);
    ce <= 1'b1; wt(TO + 10); chk(smi_o, SSI_IND_NA);
    wb(0, 4'h8, 0); chk(q, 32'h0);
    nav_u.set_sw(1, 0); wt(10); chk(smi_o, SSI_IND_CLEAR);
    nav_u.send(4'h8); wt(3); chk(smi_o, SSI_IND_CLEAR);
    nav_u.set_sw(1, 1); wt(10); chk(smi_o, SSI_IND_SET);
    wb(0, SSI_REG_STATUS, 0); chk(q, 32'h3e);
    nav_u.set_sw(0, 1);
    rst_i <= 1'b1; wt(8); chk(smi_o, SSI_IND_NA);
    rst_i <= 1'b0;
    wb(1, SSI_REG_CTRL, 32'h3); wt(10); chk(smi_o, SSI_IND_SET);
    nav_u.set_sw(0, 0); wt(10); chk(smi_o, SSI_IND_CLEAR);
    wb(0, SSI_REG_CTRL, 0); chk(q, 32'h3);
    conclude;
  end
endmodule // side_sign_indicator_tb
`default_nettype wire
